// ---- rtl/mies_pkg.sv ----
// Shared constants and types for the instruction execution subset.
`default_nettype none
package mies_pkg;
	localparam int          DATA_W      = 8;
	localparam int          FADDR_W     = 7;
	localparam int          PC_W        = 13;
	localparam int          K_W         = 11;
	localparam int          INSTR_W     = 14;
	localparam int          LATCH_W     = 5;
	localparam int          STACK_DEPTH = 8;
	localparam int          STK_PTR_W   = 3;
	localparam int          ADDR_W      = 5;
	// Instruction cycle length in clocks
	localparam int          TCY_CLKS    = 4;
	localparam logic [1:0]  TCY_LAST    = 2'(TCY_CLKS - 1);
	// Register byte offsets
	localparam logic [4:0]  OFS_INSTR   = 5'h00;
	localparam logic [4:0]  OFS_ACC     = 5'h04;
	localparam logic [4:0]  OFS_PC      = 5'h08;
	localparam logic [4:0]  OFS_LATCH   = 5'h0c;
	localparam logic [4:0]  OFS_FDATA   = 5'h10;
	localparam logic [4:0]  OFS_FPTR    = 5'h14;
	localparam logic [4:0]  OFS_STACK   = 5'h18;
	// Field positions
	localparam int          MAJ_LSB     = 11;
	localparam int          MIN_LSB     = 8;
	localparam int          BSEL_LSB    = 8;
	localparam int          DEST_BIT    = 7;
	localparam int          ZFLAG_BIT   = 8;
	localparam int          BUSY_BIT    = 31;
	localparam int          DEPTH_LSB   = 16;
	localparam int          LATCH_HI    = 4;
	localparam int          LATCH_LO    = 3;
	// Major groups and file-group minor codes
	localparam logic [2:0]  MAJ_FILE    = 3'h0;
	localparam logic [2:0]  MAJ_BTEST   = 3'h1;
	localparam logic [2:0]  MAJ_CALL    = 3'h5;
	localparam logic [2:0]  OP_FZERO    = 3'h1;
	localparam logic [2:0]  OP_AZERO    = 3'h2;
	localparam logic [2:0]  OP_FINV     = 3'h3;
	localparam logic [2:0]  OP_FDEC     = 3'h4;
	localparam logic [2:0]  OP_DSKIP    = 3'h5;
	localparam logic [2:0]  OP_ISKIP    = 3'h6;
	// Reset values
	localparam logic [12:0] PC_RST      = 13'h0000;
	localparam logic [7:0]  ACC_RST     = 8'h00;
	localparam logic [4:0]  LATCH_RST   = 5'h00;
	localparam logic [6:0]  FPTR_RST    = 7'h00;
	typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_NOP} mies_state_t;
endpackage : mies_pkg
`default_nettype wire

// ---- rtl/mies_mem_if.sv ----
// Carrier between the core, its file register memory and its return stack.
`default_nettype none
interface mies_mem_if;
	import mies_pkg::*;
	logic [FADDR_W-1:0] addr;
	logic               we;
	logic [DATA_W-1:0]  wdata;
	logic [DATA_W-1:0]  rdata;
	logic               push;
	logic [PC_W-1:0]    push_pc;
	logic [PC_W-1:0]    top_pc;
	logic [3:0]         depth;
	modport core  (output addr, we, wdata, push, push_pc, input rdata, top_pc, depth);
	modport ram   (input addr, we, wdata, output rdata);
	modport stack (input push, push_pc, output top_pc, depth);
endinterface : mies_mem_if
`default_nettype wire

// ---- rtl/mies_file_ram.sv ----
// File register memory, 128 x 8, write-first with registered read data.
`default_nettype none
module mies_file_ram
	import mies_pkg::*;
(
	input wire logic clock,   // System clock
	input wire logic sys_rst, // Async reset, high
	mies_mem_if.ram  mp       // Memory port
);
	logic [DATA_W-1:0] mem [2**FADDR_W];
	logic [DATA_W-1:0] rdata_r;

	// Write-first so a bus read right after a bus write sees new data
	always_ff @(posedge clock) begin
		if (mp.we) begin
			mem[mp.addr] <= mp.wdata;
		end
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			rdata_r <= 8'h00;
		end else if (mp.we) begin
			rdata_r <= mp.wdata;
		end else begin
			rdata_r <= mem[mp.addr];
		end
	end

	assign mp.rdata = rdata_r;
endmodule : mies_file_ram
`default_nettype wire

// ---- rtl/mies_stack.sv ----
// Hardware return stack, eight entries, wraps on overflow.
`default_nettype none
module mies_stack
	import mies_pkg::*;
(
	input wire logic  clock,   // System clock
	input wire logic  sys_rst, // Async reset, high
	mies_mem_if.stack sp       // Stack port
);
	typedef struct packed {
		logic [STK_PTR_W-1:0] ptr;
		logic [3:0]           cnt;
	} mies_stk_t;

	mies_stk_t       r;
	mies_stk_t       n;
	logic [PC_W-1:0] ent [STACK_DEPTH];

	always_comb begin
		n = r;
		if (sp.push) begin
			n.ptr = r.ptr + 3'h1;
			if (r.cnt != 4'(STACK_DEPTH)) begin
				n.cnt = r.cnt + 4'h1;
			end
		end
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			r <= '0;
			for (int i = 0; i < STACK_DEPTH; i++) begin
				ent[i] <= PC_RST;
			end
		end else begin
			r <= n;
			if (sp.push) begin
				ent[r.ptr] <= sp.push_pc;
			end
		end
	end

	assign sp.top_pc = ent[r.ptr - 3'h1];
	assign sp.depth  = r.cnt;
endmodule : mies_stack
`default_nettype wire

// ---- rtl/mies_core.sv ----
// Execution core for the instruction subset, with an Avalon-MM register slave.
//
// Notes on behaviour
// RQ1: Bit test reads bit b of file f; clear bit skips next, flags unchanged.
// RQ2: Bit test lasts two cycles when skipping, otherwise one.
// RQ3: Call pushes program counter plus one onto the return stack first.
// RQ4: Call loads its 11-bit operand into program counter bits 10 to 0.
// RQ5: Call fills counter bits 12 and 11 from latch bits 4 and 3.
// RQ6: Call always takes two instruction cycles.
// RQ7: File zeroing writes zero to register f and sets zero flag.
// RQ8: Accumulator zeroing clears the accumulator and sets zero flag.
// RQ9: Invert complements f into accumulator or f by d; zero flag follows.
// RQ10: Decrement puts f minus one by d; only zero flag updated.
// RQ11: Decrement-skip writes f minus one; zero result skips, two cycles, no flags.
// RQ12: Increment-skip writes f plus one; zero result skips, two cycles, no flags.
// RQ13: A counter change or true test costs two cycles, second is a no-op.
// RQ14: Data is eight bits wide; increment and decrement wrap before zero test.
`default_nettype none
module mies_core
	import mies_pkg::*;
(
	input  wire logic                      clock,           // 125 MHz clock
	input  wire logic                      sys_rst,         // Async reset, high
	input  wire logic [mies_pkg::ADDR_W-1:0] avs_address,   // Byte address
	input  wire logic                      avs_read,        // Read request
	input  wire logic                      avs_write,       // Write request
	input  wire logic [31:0]               avs_writedata,   // Write data
	output logic      [31:0]               avs_readdata,    // Read data
	output logic                           avs_waitrequest, // Stall
	output logic                           exec_busy        // Instruction in flight
);
	typedef struct packed {
		mies_state_t          state;
		logic [1:0]           tcy;
		logic [INSTR_W-1:0]   instr;
		logic                 pend;
		logic [DATA_W-1:0]    acc;
		logic                 z;
		logic [PC_W-1:0]      pc;
		logic [LATCH_W-1:0]   latch;
		logic [FADDR_W-1:0]   fptr;
		logic                 wait_r;
		logic [31:0]          rdata;
		logic                 busy;
	} mies_core_st_t;

	localparam mies_core_st_t CORE_RST = '{
		state: ST_IDLE, tcy: 2'h0, instr: 14'h0000, pend: 1'b0,
		acc: ACC_RST, z: 1'b0, pc: PC_RST, latch: LATCH_RST,
		fptr: FPTR_RST, wait_r: 1'b1, rdata: 32'h00000000, busy: 1'b0};

	mies_core_st_t    r;
	mies_core_st_t    n;
	mies_mem_if       mif ();
	logic             tcy_en;
	logic             commit;
	logic             req;
	logic             bus_ok;
	logic [2:0]       maj;
	logic [2:0]       minor;
	logic [2:0]       bsel;
	logic             dest_f;
	logic [K_W-1:0]   kfield;
	logic [DATA_W-1:0] res;
	logic             upd;
	logic             two;

	function automatic logic is_zero(input logic [DATA_W-1:0] v);
		return v == 8'h00;
	endfunction : is_zero

	assign maj    = r.instr[MAJ_LSB +: 3];
	assign minor  = r.instr[MIN_LSB +: 3];
	assign bsel   = r.instr[BSEL_LSB +: 3];
	assign dest_f = r.instr[DEST_BIT];
	assign kfield = r.instr[K_W-1:0];
	assign tcy_en = (r.tcy == TCY_LAST);
	assign commit = (r.state == ST_EXEC) && tcy_en;
	assign req    = avs_read || avs_write;
	// Status read stays open while busy so software can poll
	assign bus_ok = !r.busy || (avs_read && avs_address == OFS_INSTR);

	////////////////////////////////////////////////////////////////////////////////

	mies_file_ram u_ram (
		.clock   (clock),
		.sys_rst (sys_rst),
		.mp      (mif.ram)
	);

	mies_stack u_stack (
		.clock   (clock),
		.sys_rst (sys_rst),
		.sp      (mif.stack)
	);

	////////////////////////////////////////////////////////////////////////////////

	always_comb begin
		n           = r;
		n.tcy       = r.tcy + 2'h1;
		n.wait_r    = 1'b1;
		res         = 8'h00;
		upd         = 1'b0;
		two         = 1'b0;
		mif.we      = 1'b0;
		mif.wdata   = 8'h00;
		mif.push    = 1'b0;
		mif.push_pc = r.pc + 13'h0001;
		// Operand address follows the instruction while busy, else the file pointer
		mif.addr    = r.busy ? r.instr[FADDR_W-1:0] : r.fptr;

		// Bus decision: answer one cycle after the request is seen
		if (req && r.wait_r && bus_ok) begin
			n.wait_r = 1'b0;
			if (avs_read) begin
				case (avs_address)
					OFS_INSTR: n.rdata = 32'({r.busy, 17'h00000, r.instr});
					OFS_ACC:   n.rdata = 32'({r.z, r.acc});
					OFS_PC:    n.rdata = 32'(r.pc);
					OFS_LATCH: n.rdata = 32'(r.latch);
					OFS_FDATA: n.rdata = 32'(mif.rdata);
					OFS_FPTR:  n.rdata = 32'(r.fptr);
					OFS_STACK: n.rdata = 32'({mif.depth, 3'h0, mif.top_pc});
					default:   n.rdata = 32'h00000000;
				endcase
			end
		end
		// Write takes effect at the edge the master sees waitrequest low
		if (avs_write && !r.wait_r) begin
			case (avs_address)
				OFS_INSTR: begin
					n.instr = avs_writedata[INSTR_W-1:0];
					n.pend  = 1'b1;
				end
				OFS_ACC: begin
					n.acc = avs_writedata[DATA_W-1:0];
					n.z   = avs_writedata[ZFLAG_BIT];
				end
				OFS_PC:    n.pc    = avs_writedata[PC_W-1:0];
				OFS_LATCH: n.latch = avs_writedata[LATCH_W-1:0];
				OFS_FDATA: begin
					mif.we    = 1'b1;
					mif.wdata = avs_writedata[DATA_W-1:0];
				end
				OFS_FPTR:  n.fptr  = avs_writedata[FADDR_W-1:0];
				default: begin
				end
			endcase
		end

		case (r.state)
			ST_IDLE: begin
				// Start on a cycle boundary so every cycle is a full period
				if (r.pend && tcy_en) begin
					n.state = ST_EXEC;
					n.pend  = 1'b0;
				end
			end
			ST_EXEC: begin
				if (tcy_en) begin
					case (maj)
						MAJ_CALL: begin
							mif.push = 1'b1; // see RQ3
							n.pc     = {r.latch[LATCH_HI:LATCH_LO], kfield}; // see RQ4 see RQ5
							two      = 1'b1; // see RQ6
						end
						MAJ_BTEST: begin
							two = !mif.rdata[bsel]; // see RQ1 see RQ2
						end
						MAJ_FILE: begin
							case (minor)
								OP_FZERO: begin
									mif.we    = 1'b1; // see RQ7
									mif.wdata = 8'h00;
									n.z       = 1'b1;
								end
								OP_AZERO: begin
									n.acc = 8'h00; // see RQ8
									n.z   = 1'b1;
								end
								OP_FINV: begin
									res = ~mif.rdata; // see RQ9
									upd = 1'b1;
									n.z = is_zero(res);
								end
								OP_FDEC: begin
									res = mif.rdata - 8'h01; // see RQ10 see RQ14
									upd = 1'b1;
									n.z = is_zero(res);
								end
								OP_DSKIP: begin
									res = mif.rdata - 8'h01; // see RQ11 see RQ14
									upd = 1'b1;
									two = is_zero(res);
								end
								OP_ISKIP: begin
									res = mif.rdata + 8'h01; // see RQ12 see RQ14
									upd = 1'b1;
									two = is_zero(res);
								end
								default: begin
								end
							endcase
						end
						default: begin
						end
					endcase
					if (upd) begin
						if (dest_f) begin
							mif.we    = 1'b1;
							mif.wdata = res;
						end else begin
							n.acc = res;
						end
					end
					// A skip steps over the discarded word
					if (maj != MAJ_CALL) begin
						n.pc = r.pc + (two ? 13'h0002 : 13'h0001); // see RQ1
					end
					n.state = two ? ST_NOP : ST_IDLE; // see RQ13
				end
			end
			ST_NOP: begin
				if (tcy_en) begin
					n.state = ST_IDLE; // see RQ13
				end
			end
			default: n.state = ST_IDLE;
		endcase
		n.busy = (n.state != ST_IDLE) || n.pend;
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			r <= CORE_RST;
		end else begin
			r <= n;
		end
	end

	assign avs_readdata    = r.rdata;
	assign avs_waitrequest = r.wait_r;
	assign exec_busy       = r.busy;

	////////////////////////////////////////////////////////////////////////////////

	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);

	property p_btest_skip;
		commit && maj == MAJ_BTEST && !mif.rdata[bsel]
			|=> r.state == ST_NOP && r.pc == $past(r.pc) + 13'h0002 && $stable(r.z);
	endproperty
	a_btest_skip: assert property (p_btest_skip) else $error("bit test skip wrong"); // see RQ1

	property p_btest_run;
		commit && maj == MAJ_BTEST && mif.rdata[bsel]
			|=> r.state == ST_IDLE && r.pc == $past(r.pc) + 13'h0001;
	endproperty
	a_btest_run: assert property (p_btest_run) else $error("bit test no-skip wrong"); // see RQ2

	// Checked at the stack top so the stack module is covered too
	property p_call_push;
		commit && maj == MAJ_CALL |=> mif.top_pc == $past(r.pc) + 13'h0001;
	endproperty
	a_call_push: assert property (p_call_push) else $error("call push wrong"); // see RQ3

	property p_call_pc;
		commit && maj == MAJ_CALL
			|=> r.pc == {$past(r.latch[LATCH_HI:LATCH_LO]), $past(kfield)};
	endproperty
	a_call_pc: assert property (p_call_pc) else $error("call target wrong"); // see RQ5

	property p_call_two;
		commit && maj == MAJ_CALL |=> r.state == ST_NOP [*4] ##1 r.state == ST_IDLE;
	endproperty
	a_call_two: assert property (p_call_two) else $error("call not two cycles"); // see RQ6

	property p_fzero;
		commit && maj == MAJ_FILE && minor == OP_FZERO
			|-> mif.we && mif.wdata == 8'h00 ##1 r.z;
	endproperty
	a_fzero: assert property (p_fzero) else $error("file zeroing wrong"); // see RQ7

	property p_azero;
		commit && maj == MAJ_FILE && minor == OP_AZERO |=> r.acc == 8'h00 && r.z;
	endproperty
	a_azero: assert property (p_azero) else $error("accumulator zeroing wrong"); // see RQ8

	property p_finv_acc;
		commit && maj == MAJ_FILE && minor == OP_FINV && !dest_f
			|=> r.acc == ~$past(mif.rdata) && r.z == (r.acc == 8'h00);
	endproperty
	a_finv_acc: assert property (p_finv_acc) else $error("invert result wrong"); // see RQ9

	// Write-first memory shows the stored result one cycle after commit
	property p_fdec_file;
		commit && maj == MAJ_FILE && minor == OP_FDEC && dest_f
			|-> mif.we && mif.wdata == mif.rdata - 8'h01
			##1 $stable(r.acc) && r.z == (mif.rdata == 8'h00);
	endproperty
	a_fdec_file: assert property (p_fdec_file) else $error("decrement wrong"); // see RQ10

	property p_dskip;
		commit && maj == MAJ_FILE && minor == OP_DSKIP && mif.rdata == 8'h01
			|=> r.state == ST_NOP && $stable(r.z);
	endproperty
	a_dskip: assert property (p_dskip) else $error("decrement skip wrong"); // see RQ11

	property p_iskip;
		commit && maj == MAJ_FILE && minor == OP_ISKIP && !dest_f
			|=> r.acc == $past(mif.rdata) + 8'h01 && $stable(r.z)
			&& (r.state == ST_NOP) == (r.acc == 8'h00);
	endproperty
	a_iskip: assert property (p_iskip) else $error("increment skip wrong"); // see RQ12

	c_call: cover property (commit && maj == MAJ_CALL);
	c_skip: cover property (commit && maj == MAJ_BTEST && !mif.rdata[bsel]);
	c_wrap: cover property (commit && maj == MAJ_FILE && minor == OP_ISKIP && mif.rdata == 8'hff);
	c_stall: cover property (avs_write && r.busy && r.wait_r);
endmodule : mies_core
`default_nettype wire

// ---- sim/testbench.sv ----
// Self-checking bench for the instruction execution core over its register bus.
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import mies_pkg::*;
	logic              clock;
	logic              sys_rst;
	logic [ADDR_W-1:0] avs_address;
	logic              avs_read;
	logic              avs_write;
	logic [31:0]       avs_writedata;
	logic [31:0]       avs_readdata;
	logic              avs_waitrequest;
	logic              exec_busy;
	int                n_mismatch;
	int                n_compared;
	int                i;
	localparam logic [7:0] BPAT = 8'ha5;

	mies_core dut_u (
		.clock          (clock),
		.sys_rst        (sys_rst),
		.avs_address    (avs_address),
		.avs_read       (avs_read),
		.avs_write      (avs_write),
		.avs_writedata  (avs_writedata),
		.avs_readdata   (avs_readdata),
		.avs_waitrequest(avs_waitrequest),
		.exec_busy      (exec_busy)
	);

	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic end_sim();
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : end_sim

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	// Request held until waitrequest is sampled low; data taken at that edge
	task automatic bus(input logic wr_en, input logic [ADDR_W-1:0] a, input logic [31:0] wd,
		output logic [31:0] q);
		int n;
		@(posedge clock);
		avs_address   <= a;
		avs_writedata <= wd;
		avs_read      <= ~wr_en;
		avs_write     <= wr_en;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 200);
		q = avs_readdata;
		avs_read  <= 1'b0;
		avs_write <= 1'b0;
		if (avs_waitrequest !== 1'b0) begin
			n_mismatch++;
			end_sim();
		end
	endtask : bus

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask : wr

	task automatic rdchk(input string name, input logic [ADDR_W-1:0] a, input logic [31:0] exp);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		check(name, q, exp);
	endtask : rdchk

	// Busy length tells one instruction cycle from two: at most 8 clocks versus 9 or more
	task automatic exec(input logic [13:0] ins, input logic two);
		int cyc;
		int n;
		wr(OFS_INSTR, {18'h0, ins});
		cyc = 0;
		for (n = 0; n < 60; n++) begin
			@(posedge clock);
			if (exec_busy === 1'b1) begin
				cyc++;
			end else if (exec_busy === 1'b0 && cyc > 0) begin
				break;
			end
		end
		if (n >= 60) begin
			n_mismatch++;
			end_sim();
		end
		check("two_cycles", {31'h0, cyc > 8}, {31'h0, two});
	endtask : exec

	task automatic setup(input logic [6:0] f, input logic [7:0] fv, input logic [8:0] az,
		input logic [12:0] pc);
		wr(OFS_FPTR, {25'h0, f});
		wr(OFS_FDATA, {24'h0, fv});
		wr(OFS_ACC, {23'h0, az});
		wr(OFS_PC, {19'h0, pc});
	endtask : setup

	task automatic fop(input logic [2:0] op, input logic d, input logic [7:0] fv,
		input logic [8:0] az, input logic [7:0] res, input logic z, input logic skip);
		setup(7'h2a, fv, az, 13'h0100);
		exec({MAJ_FILE, op, d, 7'h2a}, skip);
		rdchk("acc", OFS_ACC, {23'h0, z, d ? az[7:0] : res});
		rdchk("fdata", OFS_FDATA, {24'h0, d ? res : fv});
		rdchk("pc", OFS_PC, skip ? 32'h0000_0102 : 32'h0000_0101);
	endtask : fop

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		sys_rst       = 1'b1;
		avs_address   = '0;
		avs_read      = 1'b0;
		avs_write     = 1'b0;
		avs_writedata = 32'h0;
		n_mismatch    = 0;
		n_compared    = 0;
		repeat (6) @(posedge clock);
		sys_rst <= 1'b0;
		// Reset state and the unmapped hole
		rdchk("acc_rst", OFS_ACC, 32'h0);
		rdchk("pc_rst", OFS_PC, 32'h0);
		rdchk("latch_rst", OFS_LATCH, 32'h0);
		rdchk("fptr_rst", OFS_FPTR, 32'h0);
		rdchk("stack_rst", OFS_STACK, 32'h0);
		wr(5'h1c, 32'hffff_ffff);
		rdchk("unmapped", 5'h1c, 32'h0);
		rdchk("acc_after_hole", OFS_ACC, 32'h0);
		// Every bit position, flag preset alternating so a stray flag write shows
		for (i = 0; i < 8; i++) begin
			setup(7'h11, BPAT, {i[0], 8'h3c}, 13'h0200);
			exec({MAJ_BTEST, 3'(i), 1'b0, 7'h11}, ~BPAT[i]);
			rdchk("btest_pc", OFS_PC, BPAT[i] ? 32'h0000_0201 : 32'h0000_0202);
			rdchk("btest_acc", OFS_ACC, {23'h0, i[0], 8'h3c});
			rdchk("btest_f", OFS_FDATA, {24'h0, BPAT});
		end
		fop(OP_FZERO, 1'b1, 8'h5c, 9'h033, 8'h00, 1'b1, 1'b0);
		fop(OP_AZERO, 1'b0, 8'h5c, 9'h077, 8'h00, 1'b1, 1'b0);
		fop(OP_FINV, 1'b0, 8'h0f, 9'h1aa, 8'hf0, 1'b0, 1'b0);
		fop(OP_FINV, 1'b1, 8'hff, 9'h0aa, 8'h00, 1'b1, 1'b0);
		fop(OP_FDEC, 1'b0, 8'h01, 9'h0aa, 8'h00, 1'b1, 1'b0);
		fop(OP_FDEC, 1'b1, 8'h00, 9'h1aa, 8'hff, 1'b0, 1'b0);
		fop(OP_DSKIP, 1'b1, 8'h01, 9'h0aa, 8'h00, 1'b0, 1'b1);
		fop(OP_DSKIP, 1'b0, 8'h00, 9'h1aa, 8'hff, 1'b1, 1'b0);
		fop(OP_ISKIP, 1'b0, 8'hff, 9'h0aa, 8'h00, 1'b0, 1'b1);
		fop(OP_ISKIP, 1'b1, 8'h7f, 9'h1aa, 8'h80, 1'b1, 1'b0);
		// Call: low latch bits set so a wrong slice is caught
		wr(OFS_LATCH, 32'h0000_000b);
		rdchk("latch", OFS_LATCH, 32'h0000_000b);
		setup(7'h00, 8'h00, 9'h1c3, 13'h0abc);
		exec({MAJ_CALL, 11'h5a5}, 1'b1);
		rdchk("call_pc", OFS_PC, 32'h0000_0da5);
		rdchk("call_stack", OFS_STACK, 32'h0001_0abd);
		rdchk("call_acc", OFS_ACC, 32'h0000_01c3);
		rdchk("last_instr", OFS_INSTR, {18'h0, MAJ_CALL, 11'h5a5});
		// Latch write issued while the call runs must stall, else the target would change
		wr(OFS_LATCH, 32'h0000_0010);
		wr(OFS_INSTR, {18'h0, MAJ_CALL, 11'h7ff});
		wr(OFS_LATCH, 32'h0000_0008);
		rdchk("call2_pc", OFS_PC, 32'h0000_17ff);
		rdchk("call2_stack", OFS_STACK, 32'h0002_0da6);
		rdchk("latch2", OFS_LATCH, 32'h0000_0008);
		// Status read is served while busy; a file-group no-op still steps the counter
		wr(OFS_INSTR, {18'h0, MAJ_FILE, 3'h0, 1'b0, 7'h2a});
		rdchk("busy_poll", OFS_INSTR, {1'b1, 17'h0, MAJ_FILE, 3'h0, 1'b0, 7'h2a});
		rdchk("nop_pc", OFS_PC, 32'h0000_1800);
		check("idle", {31'h0, exec_busy}, 32'h0);
		end_sim();
	end
endmodule : testbench
`default_nettype wire
